// ---- core/adc_control_pkg.sv ----
// Shared constants and types for the dual converter control block
package adc_control_pkg;
    // Clock and conversion timing
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int CONVERSION_TIME_NS = 1250;
    localparam int CONVERSION_CYCLES = (CONVERSION_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int COUNT_BITS = 8;
    // Result and frame layout
    localparam int WIDE_BITS = 14;
    localparam int NARROW_BITS = 12;
    localparam int FRAME_BITS = 2 * WIDE_BITS;
    localparam int FRAME_COUNT_BITS = 5;
    localparam logic [FRAME_COUNT_BITS-1:0] WIDE_LAST_SHIFT = 5'h1B;
    localparam logic [FRAME_COUNT_BITS-1:0] NARROW_LAST_SHIFT = 5'h17;
    // Values after reset
    localparam logic [WIDE_BITS-1:0] RESULT_RESET = 14'h0000;
    localparam logic PAIR_RESET = 1'b0;
    localparam logic PIN_HIGH_RESET = 1'b1;
    localparam logic PIN_LOW_RESET = 1'b0;
    // Clocks after reset before the variant strap is caught
    localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h5;
    // Converter power and activity states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_SHUTDOWN = 2'b10
    } conv_state_t;
endpackage

// ---- core/shift_link_if.sv ----
// Link between the control logic and one result shifter
`timescale 1ns/1ps
`default_nettype none
interface shift_link_if;
    import adc_control_pkg::*;
    logic load;
    logic shift;
    logic wide;
    logic [WIDE_BITS-1:0] own_word;
    logic [WIDE_BITS-1:0] other_word;
    logic bit_out;
    modport ctrl (output load, shift, wide, own_word, other_word, input bit_out);
    modport shifter (input load, shift, wide, own_word, other_word, output bit_out);
endinterface
`default_nettype wire

// ---- core/pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import adc_control_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Pin and filtered level
    input wire logic i_pin,
    output logic o_level
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_level;

    // Level changes once second and third stages agree
    always_comb begin
        next_stage = {stage[1:0], i_pin};
        next_level = (stage[1] == stage[2]) ? stage[2] : o_level;
    end

    // Registers
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            stage <= {3{RESET_LEVEL}};
            o_level <= RESET_LEVEL;
        end else begin
            stage <= next_stage;
            o_level <= next_level;
        end
    end
endmodule // pin_sync
`default_nettype wire

// ---- core/result_shifter.sv ----
// Serial result shifter: own word then the other converter's word
`timescale 1ns/1ps
`default_nettype none
module result_shifter
    import adc_control_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Control link
    shift_link_if.shifter link
);
    logic [FRAME_BITS-1:0] frame;
    logic [FRAME_BITS-1:0] next_frame;
    logic [FRAME_COUNT_BITS-1:0] count;
    logic [FRAME_COUNT_BITS-1:0] next_count;
    logic [FRAME_COUNT_BITS-1:0] last;

    // Load MSB first, advance on each accepted falling clock, hold at end
    always_comb begin
        last = link.wide ? WIDE_LAST_SHIFT : NARROW_LAST_SHIFT;
        next_frame = frame;
        next_count = count;
        if (link.load) begin
            next_frame = link.wide ? {link.own_word, link.other_word} :
                {link.own_word[NARROW_BITS-1:0], link.other_word[NARROW_BITS-1:0], 4'h0};
            next_count = '0;
        end else if (link.shift && count != last) begin
            next_frame = {frame[FRAME_BITS-2:0], 1'b0};
            next_count = count + 5'h01;
        end
    end

    // Registers
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            frame <= '0;
            count <= '0;
        end else begin
            frame <= next_frame;
            count <= next_count;
        end
    end

    assign link.bit_out = frame[FRAME_BITS-1];

    // Last bit stays driven after the full dual read
    a_hold_after_end: assert property (@(posedge i_clock) disable iff (i_reset)
        (count == last && !link.load) |=> (link.bit_out == $past(link.bit_out)))
        else $error("serial bit moved after the final bit");

    // Each accepted falling clock moves one bit on, into the other word too
    a_second_word: assert property (@(posedge i_clock) disable iff (i_reset)
        (link.shift && !link.load && count != last) |=> (count == $past(count) + 5'h01))
        else $error("shift count did not advance");
endmodule // result_shifter
`default_nettype wire

// ---- core/dual_adc_convert_read_control.sv ----
// Conversion sequencing, power mode and serial readout for a dual converter
`timescale 1ns/1ps
`default_nettype none
module dual_adc_convert_read_control
    import adc_control_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Host pins
    input wire logic i_conversion_start_n,
    input wire logic i_chip_select_n,
    input wire logic i_serial_clock,
    input wire logic i_channel_select,
    input wire logic i_reference_select,
    input wire logic i_wide_variant,
    // Codes from the analog core, same clock
    input wire logic [WIDE_BITS-1:0] i_code_a,
    input wire logic [WIDE_BITS-1:0] i_code_b,
    // Status and analog control
    output logic o_busy,
    output logic o_shutdown,
    output logic o_reference_internal,
    output logic o_channel_pair,
    // Serial data pins
    output logic o_serial_out_a,
    output logic o_serial_out_a_oe,
    output logic o_serial_out_b,
    output logic o_serial_out_b_oe
);
    localparam int conversion_gap = CONVERSION_CYCLES - 1;

    // Synchronised pin levels
    logic start_level;
    logic select_level;
    logic sclk_level;
    logic channel_level;
    logic reference_level;
    logic wide_pin_level;

    pin_sync #(.RESET_LEVEL(PIN_HIGH_RESET)) start_sync (
        .i_clock(i_clock), .i_reset(i_reset),
        .i_pin(i_conversion_start_n), .o_level(start_level));
    pin_sync #(.RESET_LEVEL(PIN_HIGH_RESET)) select_sync (
        .i_clock(i_clock), .i_reset(i_reset),
        .i_pin(i_chip_select_n), .o_level(select_level));
    pin_sync #(.RESET_LEVEL(PIN_LOW_RESET)) sclk_sync (
        .i_clock(i_clock), .i_reset(i_reset),
        .i_pin(i_serial_clock), .o_level(sclk_level));
    pin_sync #(.RESET_LEVEL(PIN_LOW_RESET)) channel_sync (
        .i_clock(i_clock), .i_reset(i_reset),
        .i_pin(i_channel_select), .o_level(channel_level));
    pin_sync #(.RESET_LEVEL(PIN_LOW_RESET)) reference_sync (
        .i_clock(i_clock), .i_reset(i_reset),
        .i_pin(i_reference_select), .o_level(reference_level));
    pin_sync #(.RESET_LEVEL(PIN_LOW_RESET)) wide_sync (
        .i_clock(i_clock), .i_reset(i_reset),
        .i_pin(i_wide_variant), .o_level(wide_pin_level));

    // Previous levels for edge detection
    logic start_prev;
    logic select_prev;
    logic sclk_prev;
    logic start_fall;
    logic start_rise;
    logic select_fall;
    logic sclk_fall;

    assign start_fall = start_prev && !start_level;
    assign start_rise = !start_prev && start_level;
    assign select_fall = select_prev && !select_level;
    assign sclk_fall = sclk_prev && !sclk_level;

    // Conversion state
    conv_state_t state;
    conv_state_t next_state;
    logic [COUNT_BITS-1:0] conv_count;
    logic [COUNT_BITS-1:0] next_conv_count;
    logic pending_pair;
    logic next_pending_pair;
    logic next_channel_pair;
    logic [WIDE_BITS-1:0] result_a;
    logic [WIDE_BITS-1:0] result_b;
    logic [WIDE_BITS-1:0] next_result_a;
    logic [WIDE_BITS-1:0] next_result_b;
    logic conv_done;
    logic next_busy;

    assign conv_done = (state == ST_CONVERT) && (conv_count == '0);

    // Next conversion state, counter, channel pair and results
    always_comb begin
        next_state = state;
        next_conv_count = conv_count;
        next_pending_pair = pending_pair;
        next_channel_pair = o_channel_pair;
        next_result_a = result_a;
        next_result_b = result_b;
        case (state)
            ST_IDLE: begin
                if (start_fall) begin
                    next_state = ST_CONVERT;
                    next_conv_count = COUNT_BITS'(CONVERSION_CYCLES - 1);
                    next_channel_pair = pending_pair;
                    next_pending_pair = channel_level;
                end
            end
            ST_CONVERT: begin
                if (conv_done) begin
                    next_result_a = i_code_a;
                    next_result_b = i_code_b;
                    next_state = start_level ? ST_IDLE : ST_SHUTDOWN;
                end else begin
                    next_conv_count = conv_count - 8'h01;
                end
            end
            ST_SHUTDOWN: begin
                if (start_rise) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_busy = (next_state == ST_CONVERT);
    end

    // Conversion registers
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state <= ST_IDLE;
            conv_count <= '0;
            pending_pair <= PAIR_RESET;
            o_channel_pair <= PAIR_RESET;
            result_a <= RESULT_RESET;
            result_b <= RESULT_RESET;
            o_busy <= 1'b0;
            o_shutdown <= 1'b0;
        end else begin
            state <= next_state;
            conv_count <= next_conv_count;
            pending_pair <= next_pending_pair;
            o_channel_pair <= next_channel_pair;
            result_a <= next_result_a;
            result_b <= next_result_b;
            o_busy <= next_busy;
            o_shutdown <= (next_state == ST_SHUTDOWN);
        end
    end

    // Variant strap, caught once its synchroniser has settled after reset
    logic wide;
    logic next_wide;
    logic strap_taken;
    logic next_strap_taken;
    logic [2:0] strap_count;
    logic [2:0] next_strap_count;

    always_comb begin
        next_wide = strap_taken ? wide : wide_pin_level;
        next_strap_count = strap_count;
        if (strap_count != STRAP_SETTLE_CYCLES) begin
            next_strap_count = strap_count + 3'h1;
        end
        next_strap_taken = (strap_count == STRAP_SETTLE_CYCLES);
    end

    // Edge history, strap and pin outputs
    logic next_oe;

    always_comb begin
        next_oe = !select_level;
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            start_prev <= PIN_HIGH_RESET;
            select_prev <= PIN_HIGH_RESET;
            sclk_prev <= PIN_LOW_RESET;
            wide <= 1'b0;
            strap_taken <= 1'b0;
            strap_count <= '0;
            o_serial_out_a_oe <= 1'b0;
            o_serial_out_b_oe <= 1'b0;
            o_reference_internal <= 1'b0;
        end else begin
            start_prev <= start_level;
            select_prev <= select_level;
            sclk_prev <= sclk_level;
            wide <= next_wide;
            strap_taken <= next_strap_taken;
            strap_count <= next_strap_count;
            o_serial_out_a_oe <= next_oe;
            o_serial_out_b_oe <= next_oe;
            o_reference_internal <= reference_level;
        end
    end

    // Shifter control: load on select fall or on completion while selected
    shift_link_if link_a ();
    shift_link_if link_b ();
    logic load;
    logic shift;

    assign load = select_fall || (conv_done && !select_level);
    assign shift = sclk_fall && !select_level && !load;
    assign link_a.load = load;
    assign link_a.shift = shift;
    assign link_a.wide = wide;
    assign link_a.own_word = next_result_a;
    assign link_a.other_word = next_result_b;
    assign link_b.load = load;
    assign link_b.shift = shift;
    assign link_b.wide = wide;
    assign link_b.own_word = next_result_b;
    assign link_b.other_word = next_result_a;

    result_shifter shifter_a (.i_clock(i_clock), .i_reset(i_reset), .link(link_a.shifter));
    result_shifter shifter_b (.i_clock(i_clock), .i_reset(i_reset), .link(link_b.shifter));

    assign o_serial_out_a = link_a.bit_out;
    assign o_serial_out_b = link_b.bit_out;

    // Conversion start and duration
    sequence s_start;
        (state == ST_IDLE) && start_fall;
    endsequence
    sequence s_full_conversion;
        o_busy ##conversion_gap (o_busy && conv_count == '0) ##1 !o_busy;
    endsequence

    a_start_raises_busy: assert property (@(posedge i_clock) disable iff (i_reset)
        s_start |=> s_full_conversion)
        else $error("busy did not span the conversion");

    a_busy_holds_high: assert property (@(posedge i_clock) disable iff (i_reset)
        (o_busy && conv_count != '0) |=> o_busy)
        else $error("busy fell before conversion end");

    a_shutdown_entry: assert property (@(posedge i_clock) disable iff (i_reset)
        (conv_done && !start_level) |=> (o_shutdown && !o_busy))
        else $error("no shutdown with start low at end");

    a_normal_stays_on: assert property (@(posedge i_clock) disable iff (i_reset)
        (conv_done && start_level) |=> (!o_shutdown && state == ST_IDLE))
        else $error("entered shutdown with start high");

    a_shutdown_exit: assert property (@(posedge i_clock) disable iff (i_reset)
        (o_shutdown && start_rise) |=> !o_shutdown)
        else $error("rising start did not leave shutdown");

    a_release_on_select: assert property (@(posedge i_clock) disable iff (i_reset)
        select_level |=> (!o_serial_out_a_oe && !o_serial_out_b_oe))
        else $error("serial outputs driven while deselected");

    a_drive_while_selected: assert property (@(posedge i_clock) disable iff (i_reset)
        !select_level |=> (o_serial_out_a_oe && o_serial_out_b_oe))
        else $error("serial outputs released while selected");

    a_msb_first: assert property (@(posedge i_clock) disable iff (i_reset)
        (select_fall && !conv_done) |=>
        (o_serial_out_a == (wide ? result_a[WIDE_BITS-1] : result_a[NARROW_BITS-1])))
        else $error("first serial bit is not the MSB");

    a_channel_latch: assert property (@(posedge i_clock) disable iff (i_reset)
        $rose(o_busy) |-> (o_channel_pair == $past(pending_pair, 1)))
        else $error("channel pair not taken from previous select");

    a_result_kept: assert property (@(posedge i_clock) disable iff (i_reset)
        (o_shutdown && $past(o_shutdown)) |-> $stable(result_a) && $stable(result_b))
        else $error("results changed during shutdown");

    a_reference_follow: assert property (@(posedge i_clock) disable iff (i_reset)
        ##1 (o_reference_internal == $past(reference_level)))
        else $error("reference choice does not follow its pin");

    // Read length stays fixed once the strap is caught
    a_strap_frozen: assert property (@(posedge i_clock) disable iff (i_reset)
        strap_taken |=> $stable(wide))
        else $error("variant strap changed after capture");
endmodule // dual_adc_convert_read_control
`default_nettype wire

// ---- testbench/host_model.sv ----
// Host-side model driving conversion start, chip select and serial clock
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic i_clock,
    // Device status and data
    input wire logic i_busy,
    input wire logic i_channel_pair,
    input wire logic i_serial_out_a,
    input wire logic i_serial_out_b,
    // Host pins
    output logic o_conversion_start_n,
    output logic o_chip_select_n,
    output logic o_serial_clock
);
    // Pins idle high; serial clock stands still outside frames
    initial begin
        o_conversion_start_n = 1'b1;
        o_chip_select_n = 1'b1;
        o_serial_clock = 1'b1;
    end

    // Start held high for the power-up time, 2800 clocks
    task automatic power_up();
        repeat (2800) @(posedge i_clock);
    endtask

    // Falling start edge; start level kept until busy falls picks the mode
    task automatic convert(input logic stay_low, output int cycles, output logic pair_seen);
        int wait_count;
        wait_count = 0;
        pair_seen = 1'bx;
        @(posedge i_clock) o_conversion_start_n <= 1'b0;
        while (i_busy !== 1'b1 && wait_count < 20) begin
            @(posedge i_clock);
            wait_count++;
        end
        if (!stay_low) begin
            o_conversion_start_n <= 1'b1;
        end
        cycles = 0;
        while (i_busy === 1'b1 && cycles < 200) begin
            @(posedge i_clock);
            cycles++;
            if (cycles == 2) begin
                pair_seen = i_channel_pair;
            end
        end
    endtask

    // Rising start edge to leave shutdown
    task automatic raise_start();
        @(posedge i_clock) o_conversion_start_n <= 1'b1;
    endtask

    // Chip select low, then one bit sampled before each serial clock fall
    task automatic read(input int bits, output logic [27:0] word_a, output logic [27:0] word_b);
        word_a = '0;
        word_b = '0;
        @(posedge i_clock) o_chip_select_n <= 1'b0;
        repeat (8) @(posedge i_clock);
        for (int i = 0; i < bits; i++) begin
            word_a = {word_a[26:0], i_serial_out_a};
            word_b = {word_b[26:0], i_serial_out_b};
            o_serial_clock <= 1'b0;
            repeat (4) @(posedge i_clock);
            o_serial_clock <= 1'b1;
            repeat (4) @(posedge i_clock);
        end
    endtask

    // Chip select high on the next clock; any quiet interval is left to the caller
    task automatic release_cs();
        @(posedge i_clock) o_chip_select_n <= 1'b1;
    endtask
endmodule // host_model
`default_nettype wire

// ---- testbench/dual_adc_convert_read_control_test.sv ----
// Self-checking testbench for the dual converter control block
`timescale 1ns/1ps
`default_nettype none
module dual_adc_convert_read_control_test;
    import adc_control_pkg::*;
    logic i_clock, i_reset, i_channel_select, i_reference_select, i_wide_variant;
    logic [WIDE_BITS-1:0] i_code_a, i_code_b;
    logic conversion_start_n, chip_select_n, serial_clock;
    logic o_busy, o_shutdown, o_reference_internal, o_channel_pair;
    logic o_serial_out_a, o_serial_out_a_oe, o_serial_out_b, o_serial_out_b_oe;
    int fail_count, cmp_count, cycles;
    logic pair;
    logic [27:0] word_a, word_b;

    // Device under test
    dual_adc_convert_read_control i_dual_adc_convert_read_control (
        .i_clock(i_clock), .i_reset(i_reset),
        .i_conversion_start_n(conversion_start_n), .i_chip_select_n(chip_select_n),
        .i_serial_clock(serial_clock), .i_channel_select(i_channel_select),
        .i_reference_select(i_reference_select), .i_wide_variant(i_wide_variant),
        .i_code_a(i_code_a), .i_code_b(i_code_b),
        .o_busy(o_busy), .o_shutdown(o_shutdown),
        .o_reference_internal(o_reference_internal), .o_channel_pair(o_channel_pair),
        .o_serial_out_a(o_serial_out_a), .o_serial_out_a_oe(o_serial_out_a_oe),
        .o_serial_out_b(o_serial_out_b), .o_serial_out_b_oe(o_serial_out_b_oe)
    );

    // Host on the far side
    host_model i_host_model (
        .i_clock(i_clock), .i_busy(o_busy), .i_channel_pair(o_channel_pair),
        .i_serial_out_a(o_serial_out_a), .i_serial_out_b(o_serial_out_b),
        .o_conversion_start_n(conversion_start_n), .o_chip_select_n(chip_select_n),
        .o_serial_clock(serial_clock)
    );

    // 40 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    // Compare and count
    task automatic check(input string what, input logic [27:0] expected, input logic [27:0] seen);
        cmp_count++;
        if (seen !== expected) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, expected, seen);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reset for 6 clocks with the variant strap set, then power-up wait
    task automatic do_reset(input logic wide);
        i_wide_variant <= wide;
        @(posedge i_clock) i_reset <= 1'b1;
        repeat (6) @(posedge i_clock);
        i_reset <= 1'b0;
        i_host_model.power_up();
    endtask

    // Output enables after chip select rises
    task automatic check_released(input string what);
        i_host_model.release_cs();
        repeat (8) @(posedge i_clock);
        check(what, 28'h0, {26'h0, o_serial_out_a_oe, o_serial_out_b_oe});
        repeat (8) @(posedge i_clock);
    endtask

    // Hang guard
    initial begin
        #1000000;
        fail_count++;
        $display("[FAIL] watchdog expected done seen running");
        complete_run();
    end

    // Test sequence
    initial begin
        i_reset = 1'b1;
        i_channel_select = 1'b1;
        i_reference_select = 1'b1;
        i_wide_variant = 1'b1;
        i_code_a = 14'h2A5C;
        i_code_b = 14'h1337;
        fail_count = 0;
        cmp_count = 0;
        do_reset(1'b1);
        check("idle outputs", 28'h0, {24'h0, o_busy, o_shutdown, o_serial_out_a_oe, o_serial_out_b_oe});
        check("reference internal", 28'h1, {27'h0, o_reference_internal});
        i_reference_select <= 1'b0;
        repeat (8) @(posedge i_clock);
        check("reference external", 28'h0, {27'h0, o_reference_internal});
        $display("test reset_reference done");
        i_host_model.convert(1'b0, cycles, pair);
        check("busy cycles", 28'(CONVERSION_CYCLES), 28'(cycles));
        check("first pair", 28'h0, {27'h0, pair});
        check("stays powered", 28'h0, {27'h0, o_shutdown});
        i_channel_select <= 1'b0;
        i_host_model.read(28, word_a, word_b);
        check("dual word a", {14'h2A5C, 14'h1337}, word_a);
        check("dual word b", {14'h1337, 14'h2A5C}, word_b);
        repeat (20) @(posedge i_clock);
        check("held oe", 28'h3, {26'h0, o_serial_out_a_oe, o_serial_out_b_oe});
        check("held bit", 28'h2, {26'h0, o_serial_out_a, o_serial_out_b});
        check_released("released oe");
        $display("test dual_read done");
        i_code_a <= 14'h3C01;
        i_code_b <= 14'h0FF2;
        i_host_model.convert(1'b0, cycles, pair);
        check("second pair", 28'h1, {27'h0, pair});
        i_host_model.read(5, word_a, word_b);
        check("partial word a", 28'h000001E, word_a);
        check_released("abort oe");
        $display("test early_release done");
        i_code_a <= 14'h15A3;
        i_code_b <= 14'h2E4D;
        i_host_model.convert(1'b1, cycles, pair);
        check("third pair", 28'h0, {27'h0, pair});
        i_code_a <= 14'h0000;
        i_code_b <= 14'h0000;
        repeat (8) @(posedge i_clock);
        check("shutdown entered", 28'h1, {27'h0, o_shutdown});
        i_host_model.read(14, word_a, word_b);
        check("kept word a", 28'h00015A3, word_a);
        check("kept word b", 28'h0002E4D, word_b);
        check_released("shutdown oe");
        i_host_model.raise_start();
        repeat (8) @(posedge i_clock);
        check("shutdown left", 28'h0, {27'h0, o_shutdown});
        $display("test shutdown done");
        i_code_a <= 14'h0ABC;
        i_code_b <= 14'h0123;
        do_reset(1'b0);
        i_host_model.convert(1'b0, cycles, pair);
        check("narrow busy", 28'(CONVERSION_CYCLES), 28'(cycles));
        i_host_model.read(24, word_a, word_b);
        check("narrow word a", 28'h0ABC123, word_a);
        check("narrow word b", 28'h0123ABC, word_b);
        check_released("narrow oe");
        $display("test narrow_variant done");
        complete_run();
    end
endmodule // dual_adc_convert_read_control_test
`default_nettype wire
